// ---- dpsm_params.svh ----
// constants for the drive power-state machine
`ifndef DPSM_PARAMS_SVH
`define DPSM_PARAMS_SVH
`define DPSM_CMD_INDEX 16'h6040
`define DPSM_CMD_RESET 16'h0000
`define DPSM_BIT_SWON 0
`define DPSM_BIT_VOLT 1
`define DPSM_BIT_RSTOP 2
`define DPSM_BIT_ENOP 3
`define DPSM_BIT_MODE4 4
`define DPSM_BIT_MODE5 5
`define DPSM_BIT_MODE6 6
`define DPSM_BIT_ACK 7
`define DPSM_BIT_MODE8 8
`define DPSM_CARE_SHUTDOWN 4'h7
`define DPSM_VAL_SHUTDOWN 4'h6
`define DPSM_CARE_SWON 4'h7
`define DPSM_VAL_SWON 4'h7
`define DPSM_CARE_ENOP 4'hf
`define DPSM_VAL_ENOP 4'hf
`define DPSM_CARE_DISOP 4'hf
`define DPSM_VAL_DISOP 4'h7
`define DPSM_CARE_RSTOP 4'h6
`define DPSM_VAL_RSTOP 4'h2
`define DPSM_CARE_DISV 4'h2
`define DPSM_VAL_DISV 4'h0
`define DPSM_MODE_INTERP 8'h07
`define DPSM_SELF_TEST_NS 1000
`define DPSM_CLK_PERIOD_NS 10
`define DPSM_SELF_TEST_CYC ((`DPSM_SELF_TEST_NS + `DPSM_CLK_PERIOD_NS - 1) / `DPSM_CLK_PERIOD_NS)
`endif

// ---- dpsm_pkg.sv ----
// types for the drive power-state machine
package dpsm_pkg;
  typedef enum logic [2:0] {
    DPSM_SELF_TEST,
    DPSM_COMM_READY,
    DPSM_ARMED,
    DPSM_STAGE_ON,
    DPSM_RUNNING,
    DPSM_RAPID_STOP,
    DPSM_ERR_RESP,
    DPSM_ERR_LATCHED
  } dpsm_state_e;
  typedef logic [15:0] dpsm_word_t;
endpackage

// ---- dpsm_cmd_if.sv ----
// decoded command word passed from the command register to the state machine
`timescale 1ns/10ps
`default_nettype none
interface dpsm_cmd_if;
  logic shutdown;
  logic switch_on;
  logic enable_op;
  logic disable_op;
  logic rapid_stop;
  logic disable_volt;
  logic ack_edge;
  logic [3:0] mode_bits;
  modport decoder (
    output shutdown, switch_on, enable_op, disable_op, rapid_stop, disable_volt,
    output ack_edge, mode_bits
  );
  modport fsm (
    input shutdown, switch_on, enable_op, disable_op, rapid_stop, disable_volt,
    input ack_edge, mode_bits
  );
endinterface
`default_nettype wire

// ---- dpsm_cmd_decode.sv ----
// command register at its object index and decoder of its bit groups
`timescale 1ns/10ps
`default_nettype none
`include "dpsm_params.svh"
module dpsm_cmd_decode (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic obj_wr_i,
  input wire logic [15:0] obj_index_i,
  input wire logic [15:0] obj_wdata_i,
  output logic [15:0] cmd_word_o,
  dpsm_cmd_if.decoder cmd
);
  dpsm_pkg::dpsm_word_t word_reg, word_next;
  logic ack_prev_reg, ack_prev_next;

  // x bits of a command are masked out by the care pattern
  function automatic logic cmd_match(input logic [3:0] low, input logic [3:0] care,
                                     input logic [3:0] val);
    cmd_match = ((low & care) == val);
  endfunction

  always_comb begin
    word_next = word_reg;
    if (obj_wr_i && (obj_index_i == `DPSM_CMD_INDEX)) begin
      word_next = obj_wdata_i;
    end
    ack_prev_next = word_reg[`DPSM_BIT_ACK];
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      word_reg <= `DPSM_CMD_RESET;
      ack_prev_reg <= 1'b0;
    end else begin
      word_reg <= word_next;
      ack_prev_reg <= ack_prev_next;
    end
  end

  // bits 15..9 are stored for read-back but never decoded
  assign cmd_word_o = word_reg;
  assign cmd.shutdown = cmd_match(word_reg[3:0], `DPSM_CARE_SHUTDOWN, `DPSM_VAL_SHUTDOWN);
  assign cmd.switch_on = cmd_match(word_reg[3:0], `DPSM_CARE_SWON, `DPSM_VAL_SWON);
  assign cmd.enable_op = cmd_match(word_reg[3:0], `DPSM_CARE_ENOP, `DPSM_VAL_ENOP);
  assign cmd.disable_op = cmd_match(word_reg[3:0], `DPSM_CARE_DISOP, `DPSM_VAL_DISOP);
  assign cmd.rapid_stop = cmd_match(word_reg[3:0], `DPSM_CARE_RSTOP, `DPSM_VAL_RSTOP);
  assign cmd.disable_volt = cmd_match(word_reg[3:0], `DPSM_CARE_DISV, `DPSM_VAL_DISV);
  assign cmd.ack_edge = word_reg[`DPSM_BIT_ACK] & ~ack_prev_reg;
  assign cmd.mode_bits = {word_reg[`DPSM_BIT_MODE8], word_reg[`DPSM_BIT_MODE6],
                          word_reg[`DPSM_BIT_MODE5], word_reg[`DPSM_BIT_MODE4]};
endmodule // dpsm_cmd_decode
`default_nettype wire

// ---- dpsm_drive_fsm.sv ----
// drive power-state machine driven by the host command word
//
// Summary of operation
// - reset enters self-test, runs it unprompted
// - passed self-test enables CAN, communication-ready
// - low nibble decoded as one command group
// - shutdown arms from comm-ready only with both enable inputs
// - switch-on in armed turns power stage on
// - enable-operation in stage-on starts regulated running
// - rapid-stop in running brakes per selection
// - disable voltage drops to comm-ready, stage disabled; disable operation steps back to stage-on
// - disabled stage stops all switches, motor coasts
// - disabled states engage the mechanical brake
// - enabled power stage releases the fitted brake
// - bit 7 rising edge acknowledges cleared errors
// - bits 4,5,6,8 go to mode logic
// - command word is 16-bit read/write object
`timescale 1ns/10ps
`default_nettype none
`include "dpsm_params.svh"
module dpsm_drive_fsm (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic obj_wr_i,
  input wire logic [15:0] obj_index_i,
  input wire logic [15:0] obj_wdata_i,
  output logic [15:0] obj_rdata_o,
  input wire logic stage_enable_pin_i,
  input wire logic ctrl_enable_pin_i,
  input wire logic brake_fitted_pin_i,
  input wire logic self_test_ok_i,
  input wire logic error_i,
  input wire logic error_critical_i,
  input wire logic error_cause_active_i,
  input wire logic fault_reaction_done_i,
  input wire logic rapid_stop_done_i,
  input wire logic [7:0] operating_mode_sel_i,
  output logic [2:0] state_o,
  output logic can_enable_o,
  output logic power_stage_on_o,
  output logic regulate_o,
  output logic rapid_stop_brake_o,
  output logic fault_reaction_o,
  output logic brake_release_o,
  output logic [3:0] mode_bits_o,
  output logic interp_enable_o
);
  localparam int unsigned SELF_TEST_CYC = `DPSM_SELF_TEST_CYC;
  localparam int unsigned CNT_W = $clog2(SELF_TEST_CYC + 1);

  dpsm_cmd_if cmd_bus ();

  dpsm_cmd_decode u_decode (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .obj_wr_i(obj_wr_i),
    .obj_index_i(obj_index_i),
    .obj_wdata_i(obj_wdata_i),
    .cmd_word_o(obj_rdata_o),
    .cmd(cmd_bus.decoder)
  );

  // pin synchronisers: stage enable, controller enable, brake strap
  logic [2:0] pin_meta_reg, pin_meta_next;
  logic [2:0] pin_sync_reg, pin_sync_next;
  logic [2:0] pin_raw;

  assign pin_raw = {brake_fitted_pin_i, ctrl_enable_pin_i, stage_enable_pin_i};

  always_comb begin
    pin_meta_next = pin_raw;
    pin_sync_next = pin_meta_reg;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end else begin
      pin_meta_reg <= pin_meta_next;
      pin_sync_reg <= pin_sync_next;
    end
  end

  logic enables_ok;
  logic brake_fitted;
  assign enables_ok = pin_sync_reg[0] & pin_sync_reg[1];
  assign brake_fitted = pin_sync_reg[2];

  // state machine
  dpsm_pkg::dpsm_state_e state_reg, state_next;
  logic [CNT_W-1:0] test_cnt_reg, test_cnt_next;
  logic critical_reg, critical_next;

  always_comb begin
    state_next = state_reg;
    test_cnt_next = test_cnt_reg;
    critical_next = critical_reg;
    if (error_i && (state_reg != dpsm_pkg::DPSM_ERR_RESP) &&
        (state_reg != dpsm_pkg::DPSM_ERR_LATCHED)) begin
      state_next = dpsm_pkg::DPSM_ERR_RESP;
      critical_next = error_critical_i;
    end else begin
      unique case (state_reg)
        dpsm_pkg::DPSM_SELF_TEST: begin
          // test waits its minimum time, then needs the pass verdict
          if (test_cnt_reg != CNT_W'(SELF_TEST_CYC)) begin
            test_cnt_next = test_cnt_reg + CNT_W'(1);
          end else if (self_test_ok_i) begin
            state_next = dpsm_pkg::DPSM_COMM_READY;
          end
        end
        dpsm_pkg::DPSM_COMM_READY: begin
          if (cmd_bus.shutdown && enables_ok) begin
            state_next = dpsm_pkg::DPSM_ARMED;
          end
        end
        dpsm_pkg::DPSM_ARMED: begin
          if (cmd_bus.disable_volt) begin
            state_next = dpsm_pkg::DPSM_COMM_READY;
          end else if (cmd_bus.switch_on) begin
            state_next = dpsm_pkg::DPSM_STAGE_ON;
          end
        end
        dpsm_pkg::DPSM_STAGE_ON: begin
          if (cmd_bus.disable_volt) begin
            state_next = dpsm_pkg::DPSM_COMM_READY;
          end else if (cmd_bus.shutdown) begin
            state_next = dpsm_pkg::DPSM_ARMED;
          end else if (cmd_bus.enable_op) begin
            state_next = dpsm_pkg::DPSM_RUNNING;
          end
        end
        dpsm_pkg::DPSM_RUNNING: begin
          if (cmd_bus.disable_volt) begin
            state_next = dpsm_pkg::DPSM_COMM_READY;
          end else if (cmd_bus.rapid_stop) begin
            state_next = dpsm_pkg::DPSM_RAPID_STOP;
          end else if (cmd_bus.shutdown) begin
            state_next = dpsm_pkg::DPSM_ARMED;
          end else if (cmd_bus.disable_op) begin
            state_next = dpsm_pkg::DPSM_STAGE_ON;
          end
        end
        dpsm_pkg::DPSM_RAPID_STOP: begin
          if (cmd_bus.disable_volt || rapid_stop_done_i) begin
            state_next = dpsm_pkg::DPSM_COMM_READY;
          end
        end
        dpsm_pkg::DPSM_ERR_RESP: begin
          // critical errors skip the fault reaction altogether
          if (critical_reg || fault_reaction_done_i) begin
            state_next = dpsm_pkg::DPSM_ERR_LATCHED;
          end
        end
        dpsm_pkg::DPSM_ERR_LATCHED: begin
          if (cmd_bus.ack_edge && !error_cause_active_i) begin
            state_next = dpsm_pkg::DPSM_COMM_READY;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= dpsm_pkg::DPSM_SELF_TEST;
      test_cnt_reg <= '0;
      critical_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      test_cnt_reg <= test_cnt_next;
      critical_reg <= critical_next;
    end
  end

  // registered outputs, computed from the next state so they track it exactly
  logic can_en_reg, can_en_next;
  logic power_reg, power_next;
  logic regulate_reg, regulate_next;
  logic rstop_reg, rstop_next;
  logic freact_reg, freact_next;
  logic brake_rel_reg, brake_rel_next;
  logic [3:0] mode_reg, mode_next;
  logic interp_reg, interp_next;

  always_comb begin
    can_en_next = (state_next != dpsm_pkg::DPSM_SELF_TEST);
    power_next = (state_next == dpsm_pkg::DPSM_STAGE_ON) ||
                 (state_next == dpsm_pkg::DPSM_RUNNING) ||
                 (state_next == dpsm_pkg::DPSM_RAPID_STOP) ||
                 (state_next == dpsm_pkg::DPSM_ERR_RESP);
    regulate_next = (state_next == dpsm_pkg::DPSM_RUNNING);
    rstop_next = (state_next == dpsm_pkg::DPSM_RAPID_STOP);
    freact_next = (state_next == dpsm_pkg::DPSM_ERR_RESP) && !critical_next;
    // brake stays applied whenever the stage is off, or no brake is fitted
    brake_rel_next = power_next && brake_fitted;
    // mode bits only reach the mode logic while it is regulating
    mode_next = regulate_next ? cmd_bus.mode_bits : 4'h0;
    interp_next = regulate_next && cmd_bus.mode_bits[0] &&
                  (operating_mode_sel_i == `DPSM_MODE_INTERP);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      can_en_reg <= 1'b0;
      power_reg <= 1'b0;
      regulate_reg <= 1'b0;
      rstop_reg <= 1'b0;
      freact_reg <= 1'b0;
      brake_rel_reg <= 1'b0;
      mode_reg <= 4'h0;
      interp_reg <= 1'b0;
    end else begin
      can_en_reg <= can_en_next;
      power_reg <= power_next;
      regulate_reg <= regulate_next;
      rstop_reg <= rstop_next;
      freact_reg <= freact_next;
      brake_rel_reg <= brake_rel_next;
      mode_reg <= mode_next;
      interp_reg <= interp_next;
    end
  end

  assign state_o = state_reg;
  assign can_enable_o = can_en_reg;
  assign power_stage_on_o = power_reg;
  assign regulate_o = regulate_reg;
  assign rapid_stop_brake_o = rstop_reg;
  assign fault_reaction_o = freact_reg;
  assign brake_release_o = brake_rel_reg;
  assign mode_bits_o = mode_reg;
  assign interp_enable_o = interp_reg;
endmodule // dpsm_drive_fsm
`default_nettype wire

// ---- dpsm_host_model.sv ----
// host model that writes the command object and polls the state
`timescale 1ns/10ps
`default_nettype none
module dpsm_host_model (
  input wire logic clk_i,
  input wire logic [2:0] state_i,
  output logic wr_o,
  output logic [15:0] index_o,
  output logic [15:0] wdata_o
);
  initial begin
    wr_o = 1'b0;
    index_o = 16'h0000;
    wdata_o = 16'h0000;
  end
  task automatic put(input logic [15:0] idx, input logic [15:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    index_o <= idx;
    wdata_o <= {7'h00, d[8:0]};
    @(posedge clk_i);
    wr_o <= 1'b0;
    // released lines show a changed value, not the last one
    index_o <= ~idx;
    wdata_o <= ~{7'h00, d[8:0]};
  endtask
  // changes take time, so the next command waits for the state
  task automatic await(input logic [2:0] want, output logic hit);
    hit = 1'b0;
    for (int i = 0; i < 300 && !hit; i++) begin
      @(negedge clk_i);
      hit = (state_i === want);
    end
  endtask
endmodule // dpsm_host_model
`default_nettype wire

// ---- dpsm_drive_fsm_checker.sv ----
// port assertions for the drive power-state machine
`timescale 1ns/10ps
`default_nettype none
module dpsm_drive_fsm_checker (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic obj_wr_i,
  input wire logic [15:0] obj_index_i,
  input wire logic [15:0] obj_wdata_i,
  input wire logic [15:0] obj_rdata_o,
  input wire logic error_i,
  input wire logic error_critical_i,
  input wire logic [2:0] state_o,
  input wire logic can_enable_o,
  input wire logic power_stage_on_o,
  input wire logic regulate_o,
  input wire logic rapid_stop_brake_o,
  input wire logic brake_release_o,
  input wire logic [3:0] mode_bits_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  AST_RESET_SELF_TEST: assert property ($past(sys_rst_i) |-> state_o == 3'h0 && !can_enable_o)
    else $error("not in self-test after reset");
  AST_CAN_READY: assert property (state_o == 3'h1 |-> can_enable_o)
    else $error("can off in comm-ready");
  AST_POWER_STATES: assert property (power_stage_on_o == (state_o inside {[3'h3:3'h6]}))
    else $error("power stage wrong for state");
  AST_BRAKE: assert property (brake_release_o |-> power_stage_on_o)
    else $error("brake released while stage off");
  AST_RUN: assert property (regulate_o == (state_o == 3'h4))
    else $error("regulate wrong for state");
  AST_RSTOP: assert property (rapid_stop_brake_o == (state_o == 3'h5))
    else $error("rapid-stop braking wrong for state");
  AST_MODE_GATE: assert property (state_o != 3'h4 |-> mode_bits_o == 4'h0)
    else $error("mode bits passed outside running");
  AST_WORD: assert property (obj_wr_i && obj_index_i == 16'h6040 |=>
    obj_rdata_o == $past(obj_wdata_i)) else $error("word not stored");
  AST_ERR: assert property (error_i && state_o inside {[3'h1:3'h5]} |=> state_o == 3'h6)
    else $error("error not answered");
  AST_CRIT: assert property (state_o == 3'h6 && $past(state_o) != 3'h6
    && $past(error_critical_i) |=> state_o == 3'h7) else $error("critical not latched");
  cover property (state_o == 3'h5);
  cover property ($past(state_o) == 3'h7 && state_o == 3'h1);
  cover property (mode_bits_o == 4'hf);
endmodule // dpsm_drive_fsm_checker
bind dpsm_drive_fsm dpsm_drive_fsm_checker u_chk (
  .clk_i, .sys_rst_i, .obj_wr_i, .obj_index_i, .obj_wdata_i, .obj_rdata_o, .error_i,
  .error_critical_i, .state_o, .can_enable_o, .power_stage_on_o, .regulate_o,
  .rapid_stop_brake_o, .brake_release_o, .mode_bits_o
);
`default_nettype wire

// ---- tb_dpsm_drive_fsm.sv ----
// self-checking bench for the drive power-state machine
`timescale 1ns/10ps
`default_nettype none
module tb_dpsm_drive_fsm;
  logic clk_i, sys_rst_i, wr, hit, se, ce, ok, err, crit, cause, frd, rsd;
  logic can, pwr, run, rsb, frx, brk, ipe;
  logic [15:0] idx, wd, rd;
  logic [3:0] mb;
  logic [2:0] st;
  int miscompares = 0;
  int checked = 0;
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  dpsm_drive_fsm u_dut (
    .clk_i, .sys_rst_i, .obj_wr_i(wr), .obj_index_i(idx), .obj_wdata_i(wd), .obj_rdata_o(rd),
    .stage_enable_pin_i(se), .ctrl_enable_pin_i(ce), .brake_fitted_pin_i(1'b1),
    .self_test_ok_i(ok), .error_i(err), .error_critical_i(crit), .error_cause_active_i(cause),
    .fault_reaction_done_i(frd), .rapid_stop_done_i(rsd), .operating_mode_sel_i(8'h07),
    .state_o(st), .can_enable_o(can), .power_stage_on_o(pwr), .regulate_o(run),
    .rapid_stop_brake_o(rsb), .fault_reaction_o(frx), .brake_release_o(brk),
    .mode_bits_o(mb), .interp_enable_o(ipe)
  );
  dpsm_host_model u_host (.clk_i, .state_i(st), .wr_o(wr), .index_o(idx), .wdata_o(wd));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmd(input logic [15:0] w, input logic [2:0] want);
    u_host.put(16'h6040, w);
    u_host.await(want, hit);
    check(16'(st), 16'(want));
  endtask
  task automatic hold(input logic [2:0] want);
    repeat (6) @(negedge clk_i);
    check(16'(st), 16'(want));
  endtask
  task automatic fault(input logic c);
    @(posedge clk_i);
    err <= 1'b1;
    crit <= c;
    cause <= 1'b1;
    @(posedge clk_i);
    err <= 1'b0;
  endtask
  initial begin
    {se, ce, ok, err, crit, cause, frd, rsd} = 8'h00;
    sys_rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (50) @(negedge clk_i);
    check(16'(st), 16'h0000);
    repeat (70) @(posedge clk_i);
    ok <= 1'b1;
    u_host.await(3'h1, hit);
    check(16'(can), 16'h0001);
    u_host.put(16'h6040, 16'h0006);
    @(posedge clk_i);
    se <= 1'b1;
    hold(3'h1);
    @(posedge clk_i);
    ce <= 1'b1;
    u_host.await(3'h2, hit);
    check(16'(st), 16'h0002);
    cmd(16'h0007, 3'h3);
    check(16'({pwr, brk}), 16'h0003);
    cmd(16'h000f, 3'h4);
    check(16'(run), 16'h0001);
    u_host.put(16'h6040, 16'h017f);
    @(negedge clk_i);
    check(rd, 16'h017f);
    hold(3'h4);
    check(16'({mb, ipe}), 16'h001f);
    u_host.put(16'h6041, 16'h0000);
    hold(3'h4);
    check(rd, 16'h017f);
    cmd(16'h0007, 3'h3);
    cmd(16'h000f, 3'h4);
    cmd(16'h000b, 3'h5);
    check(16'(rsb), 16'h0001);
    @(posedge clk_i);
    rsd <= 1'b1;
    @(posedge clk_i);
    rsd <= 1'b0;
    u_host.await(3'h1, hit);
    check(16'({st, pwr, brk}), 16'h0004);
    for (int k = 2; k < 5; k++) begin
      cmd(16'h0006, 3'h2);
      if (k > 2) cmd(16'h0007, 3'h3);
      if (k > 3) cmd(16'h000f, 3'h4);
      cmd(16'h0000, 3'h1);
    end
    cmd(16'h0006, 3'h2);
    cmd(16'h000f, 3'h4);
    cmd(16'h0006, 3'h2);
    cmd(16'h000f, 3'h4);
    fault(1'b0);
    u_host.await(3'h6, hit);
    check(16'({st, frx, pwr}), 16'h001b);
    @(posedge clk_i);
    frd <= 1'b1;
    @(posedge clk_i);
    frd <= 1'b0;
    u_host.await(3'h7, hit);
    check(16'({st, pwr, brk}), 16'h001c);
    u_host.put(16'h6040, 16'h0080);
    hold(3'h7);
    @(posedge clk_i);
    cause <= 1'b0;
    u_host.put(16'h6040, 16'h0000);
    cmd(16'h0080, 3'h1);
    cmd(16'h0006, 3'h2);
    fault(1'b1);
    u_host.await(3'h6, hit);
    cmd(16'h0006, 3'h7);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    check(16'({st, can, pwr}), 16'h0000);
    results();
  end
  initial begin
    #500us;
    miscompares++;
    results();
  end
endmodule // tb_dpsm_drive_fsm
`default_nettype wire
